// ==== rtl/gp1_port.sv ====
// Eight-pin general-purpose I/O port with latch, direction and pull-up registers.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module gp1_port #(
  parameter logic [gp1_pkg::GP1_W-1:0] OPEN_DRAIN_MASK = gp1_pkg::GP1_OPEN_DRAIN_MASK,
  parameter logic [gp1_pkg::GP1_W-1:0] NO_PULLUP_MASK = gp1_pkg::GP1_NO_PULLUP_MASK
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [gp1_pkg::GP1_AW-1:0] addr,
  input wire logic [gp1_pkg::GP1_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic rd_rmw,
  output logic [gp1_pkg::GP1_W-1:0] rdata,
  input wire logic standby_stop_watch,
  input wire logic standby_float_select,
  input wire logic [1:0] ext_irq_control_zero,
  input wire logic [1:0] irq_pin_select_control,
  input wire logic [gp1_pkg::GP1_W-1:0] periph_oe,
  input wire logic [gp1_pkg::GP1_W-1:0] periph_out,
  output logic [gp1_pkg::GP1_W-1:0] periph_in,
  input wire logic [gp1_pkg::GP1_W-1:0] pin_in,
  output logic [gp1_pkg::GP1_W-1:0] pin_out,
  output logic [gp1_pkg::GP1_W-1:0] pin_oe_n,
  output logic [gp1_pkg::GP1_W-1:0] pin_pullup_en
);
  import gp1_pkg::*;

  // --------------------------------------------------------------------------
  // Registers and nets
  // --------------------------------------------------------------------------
  logic [GP1_W-1:0] port_output_latch_q;
  logic [GP1_W-1:0] port_output_latch_d;
  logic [GP1_W-1:0] port_direction_q;
  logic [GP1_W-1:0] port_direction_d;
  logic [GP1_W-1:0] port_resistor_enable_q;
  logic [GP1_W-1:0] port_resistor_enable_d;
  logic [GP1_W-1:0] rdata_q;
  logic [GP1_W-1:0] rdata_d;
  logic [GP1_W-1:0] pin_sync;

  wire sel_latch;
  wire sel_dir;
  wire sel_pull;
  wire wr_latch;
  wire wr_dir;
  wire wr_pull;
  wire float_force;
  wire [GP1_W-1:0] keep_input;
  wire [GP1_W-1:0] pin_level;
  wire [GP1_W-1:0] port_owned;
  wire [GP1_W-1:0] latch_view;
  wire [GP1_W-1:0] read_mux;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  assign sel_latch = (addr == GP1_OFS_LATCH);
  assign sel_dir = (addr == GP1_OFS_DIR);
  assign sel_pull = (addr == GP1_OFS_PULL);
  assign wr_latch = wr_stb & sel_latch;
  assign wr_dir = wr_stb & sel_dir;
  assign wr_pull = wr_stb & sel_pull;

  // --------------------------------------------------------------------------
  // Register next values
  // --------------------------------------------------------------------------
  // The latch takes every write whatever the direction, so an input pin
  // can be preloaded before it is turned into an output.
  assign port_output_latch_d = wr_latch ? wdata : port_output_latch_q;
  assign port_direction_d = wr_dir ? wdata : port_direction_q;
  // Bit two is stored like any other even though its pin has no pull-up.
  assign port_resistor_enable_d = wr_pull ? wdata : port_resistor_enable_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      port_output_latch_q <= GP1_RST_LATCH;
      port_direction_q <= GP1_RST_DIR;
      port_resistor_enable_q <= GP1_RST_PULL;
    end
    else
    begin
      port_output_latch_q <= port_output_latch_d;
      port_direction_q <= port_direction_d;
      port_resistor_enable_q <= port_resistor_enable_d;
    end
  end

  // --------------------------------------------------------------------------
  // Input path
  // --------------------------------------------------------------------------
  gp1_sync #(
    .W(GP1_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(pin_in),
    .q(pin_sync)
  );

  // Float is applied only in stop or watch with the select bit set.
  assign float_force = standby_stop_watch & standby_float_select;

  // Pins four and six stay open as wake sources when both enables are set.
  generate
    for (genvar i = 0; i < GP1_W; i++)
    begin : g_keep
      if (i == GP1_PIN_FOUR)
      begin : g_four
        assign keep_input[i] = ext_irq_control_zero[0] & irq_pin_select_control[0];
      end
      else if (i == GP1_PIN_SIX)
      begin : g_six
        assign keep_input[i] = ext_irq_control_zero[1] & irq_pin_select_control[1];
      end
      else
      begin : g_plain
        assign keep_input[i] = 1'b0;
      end
    end
  endgenerate

  // Blocking the input avoids leakage through a floating receiver.
  assign pin_level = float_force ? (pin_sync & keep_input) : pin_sync;
  assign periph_in = pin_level;

  // --------------------------------------------------------------------------
  // Pin cells
  // --------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < GP1_W; i++)
    begin : g_pin
      gp1_pin_cell #(
        .OPEN_DRAIN(OPEN_DRAIN_MASK[i]),
        .HAS_PULLUP(~NO_PULLUP_MASK[i])
      ) u_cell (
        .dir(port_direction_q[i]),
        .latch(port_output_latch_q[i]),
        .periph_oe(periph_oe[i]),
        .periph_out(periph_out[i]),
        .float_force(float_force),
        .pull_bit(port_resistor_enable_q[i]),
        .pin_out(pin_out[i]),
        .pin_oe_n(pin_oe_n[i]),
        .pullup_en(pin_pullup_en[i])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // A pin counts as port-owned output only when no peripheral drives it.
  assign port_owned = port_direction_q & ~periph_oe;
  // Read-modify-write must see the latch, or a bit update would copy pin
  // levels of input pins back into their latches.
  assign latch_view = rd_rmw ? port_output_latch_q
    : ((port_output_latch_q & port_owned) | (pin_level & ~port_owned));
  assign read_mux = sel_latch ? latch_view
    : sel_dir ? port_direction_q
    : sel_pull ? port_resistor_enable_q
    : GP1_RD_ZERO;
  assign rdata_d = rd_stb ? read_mux : GP1_RD_ZERO;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_q <= GP1_RD_ZERO;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  wire [GP1_W-1:0] own_drive;
  assign own_drive = port_owned & ~OPEN_DRAIN_MASK & {GP1_W{~float_force}};

  chk_latch_on_pin: assert property (
    ((pin_out ^ port_output_latch_q) & own_drive) == GP1_RD_ZERO
    && (pin_oe_n & own_drive) == GP1_RD_ZERO)
    else $error("Port output pin does not carry its latch value.");

  chk_write_latch: assert property (
    wr_stb && addr == GP1_OFS_LATCH |=> port_output_latch_q == $past(wdata))
    else $error("Latch write not stored.");

  chk_input_undriven: assert property (
    (~pin_oe_n & ~port_direction_q & ~periph_oe) == GP1_RD_ZERO)
    else $error("Input pin is being driven.");

  chk_read_rmw: assert property (
    rd_stb && rd_rmw && addr == GP1_OFS_LATCH |=> rdata == $past(port_output_latch_q))
    else $error("Read-modify-write read did not return the latch.");

  chk_read_normal: assert property (
    rd_stb && !rd_rmw && addr == GP1_OFS_LATCH
    |=> rdata == $past(latch_view))
    else $error("Normal read returned the wrong source.");

  chk_periph_route: assert property (
    !float_force |-> ((pin_out ^ periph_out) & periph_oe) == GP1_RD_ZERO)
    else $error("Peripheral output not routed to pin.");

  chk_reset_dir: assert property (
    $fell(rst) |-> port_direction_q == GP1_RST_DIR && pin_oe_n == ~GP1_RD_ZERO)
    else $error("Direction not cleared by reset.");

  chk_float_hiz: assert property (
    float_force |-> pin_oe_n == ~GP1_RD_ZERO && (periph_in & ~keep_input) == GP1_RD_ZERO)
    else $error("Standby float not applied.");

  chk_float_keep: assert property (
    float_force && keep_input[GP1_PIN_FOUR] |-> periph_in[GP1_PIN_FOUR] == pin_sync[GP1_PIN_FOUR])
    else $error("Wake input of pin four was blocked.");

  chk_hold_levels: assert property (
    standby_stop_watch && !standby_float_select && $stable(port_direction_q)
    && $stable(port_output_latch_q) && $stable(periph_oe) && $stable(periph_out)
    && $stable(standby_float_select) |-> $stable(pin_oe_n))
    else $error("Pin state changed in standby without float.");

  chk_pull_low: assert property (
    (pin_pullup_en & ~pin_oe_n & ~pin_out) == GP1_RD_ZERO)
    else $error("Pull-up left on a pin driven low.");

  chk_pull_two: assert property (
    !pin_pullup_en[GP1_PIN_TWO])
    else $error("Pin two shows a pull-up.");

  chk_od_high: assert property (
    ((~pin_oe_n & pin_out) & OPEN_DRAIN_MASK) == GP1_RD_ZERO)
    else $error("Open-drain pin driven high.");

  chk_sync_delay: assert property (
    !float_force && !$past(rst) && !$past(rst, GP1_SYNC_STAGES)
    |-> pin_level == $past(pin_in, GP1_SYNC_STAGES))
    else $error("Pin level not two cycles behind the pin.");

  // --------------------------------------------------------------------------
  // Register file checks
  // --------------------------------------------------------------------------
  chk_write_dir: assert property (
    wr_stb && addr == GP1_OFS_DIR |=> port_direction_q == $past(wdata))
    else $error("Direction write not stored.");

  chk_write_pull: assert property (
    wr_stb && addr == GP1_OFS_PULL |=> port_resistor_enable_q == $past(wdata))
    else $error("Pull-up enable write not stored.");

  chk_latch_hold: assert property (
    !(wr_stb && addr == GP1_OFS_LATCH) |=> $stable(port_output_latch_q))
    else $error("Latch changed without a latch write.");

  chk_dir_hold: assert property (
    !(wr_stb && addr == GP1_OFS_DIR) |=> $stable(port_direction_q))
    else $error("Direction changed without a direction write.");

  chk_pull_hold: assert property (
    !(wr_stb && addr == GP1_OFS_PULL) |=> $stable(port_resistor_enable_q))
    else $error("Pull-up enable changed without a write.");

  chk_read_dir: assert property (
    rd_stb && addr == GP1_OFS_DIR |=> rdata == $past(port_direction_q))
    else $error("Direction read returned the wrong value.");

  chk_read_pull: assert property (
    rd_stb && addr == GP1_OFS_PULL |=> rdata == $past(port_resistor_enable_q))
    else $error("Pull-up enable read returned the wrong value.");

  chk_read_owned: assert property (
    rd_stb && !rd_rmw && addr == GP1_OFS_LATCH
    |=> ((rdata ^ $past(port_output_latch_q)) & $past(port_owned)) == GP1_RD_ZERO)
    else $error("Output port read did not return the latch.");

  chk_read_input: assert property (
    rd_stb && !rd_rmw && addr == GP1_OFS_LATCH
    |=> ((rdata ^ $past(pin_level)) & ~$past(port_owned)) == GP1_RD_ZERO)
    else $error("Input or peripheral pin read did not return the pin level.");

  // --------------------------------------------------------------------------
  // Pin drive and input checks
  // --------------------------------------------------------------------------
  chk_keep_six: assert property (
    float_force && keep_input[GP1_PIN_SIX] |-> periph_in[GP1_PIN_SIX] == pin_sync[GP1_PIN_SIX])
    else $error("Wake input of pin six was blocked.");

  chk_input_level: assert property (
    !float_force |-> periph_in == pin_sync)
    else $error("Peripheral input does not follow the pin level.");

  chk_od_low: assert property (
    (pin_oe_n & port_owned & OPEN_DRAIN_MASK & ~port_output_latch_q
    & {GP1_W{~float_force}}) == GP1_RD_ZERO)
    else $error("Open-drain pin not pulled low for a latch zero.");

  chk_periph_drive: assert property (
    !float_force |-> (pin_oe_n & periph_oe & ~(OPEN_DRAIN_MASK & periph_out)) == GP1_RD_ZERO)
    else $error("Peripheral output enable did not drive the pin.");

  chk_drive_map: assert property (
    !float_force
    |-> pin_oe_n == ~((port_direction_q | periph_oe) & ~(OPEN_DRAIN_MASK & pin_out)))
    else $error("Pin drive does not match direction and peripheral enables.");

  chk_pin_out_src: assert property (
    ((pin_out ^ port_output_latch_q) & ~periph_oe) == GP1_RD_ZERO)
    else $error("Port pin value does not come from the latch.");

  chk_pull_exact: assert property (
    pin_pullup_en == (port_resistor_enable_q & ~NO_PULLUP_MASK & ~(~pin_oe_n & ~pin_out)))
    else $error("Pull-up connection does not match its enable.");
endmodule

// ==== rtl/gp1_pkg.sv ====
// Shared constants for the eight-pin general-purpose port.
package gp1_pkg;
  // --------------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------------
  localparam int GP1_W = 8;
  localparam int GP1_AW = 4;
  localparam int GP1_SYNC_STAGES = 2;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [GP1_AW-1:0] GP1_OFS_LATCH = 4'h0;
  localparam logic [GP1_AW-1:0] GP1_OFS_DIR = 4'h1;
  localparam logic [GP1_AW-1:0] GP1_OFS_PULL = 4'h2;

  // --------------------------------------------------------------------------
  // Reset values and pin masks
  // --------------------------------------------------------------------------
  localparam logic [GP1_W-1:0] GP1_RST_LATCH = 8'h00;
  localparam logic [GP1_W-1:0] GP1_RST_DIR = 8'h00;
  localparam logic [GP1_W-1:0] GP1_RST_PULL = 8'h00;
  localparam logic [GP1_W-1:0] GP1_RD_ZERO = 8'h00;
  localparam logic [GP1_W-1:0] GP1_OPEN_DRAIN_MASK = 8'h00;
  localparam logic [GP1_W-1:0] GP1_NO_PULLUP_MASK = 8'h04;
  localparam int GP1_PIN_TWO = 2;
  localparam int GP1_PIN_FOUR = 4;
  localparam int GP1_PIN_SIX = 6;
endpackage

// ==== rtl/gp1_sync.sv ====
// Two-flop level synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module gp1_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import gp1_pkg::*;

  logic [W-1:0] meta_q;

  // --------------------------------------------------------------------------
  // Stages
  // --------------------------------------------------------------------------
  // The first stage feeds only the second, so no logic sees a metastable bit.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==== rtl/gp1_pin_cell.sv ====
// Output driver, open-drain and pull-up control for one port pin.
`timescale 1ns/1ps
module gp1_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit HAS_PULLUP = 1'b1
) (
  input wire logic dir,
  input wire logic latch,
  input wire logic periph_oe,
  input wire logic periph_out,
  input wire logic float_force,
  input wire logic pull_bit,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pullup_en
);
  import gp1_pkg::*;

  wire drive_req;
  wire drive_val;
  wire driving;

  // --------------------------------------------------------------------------
  // Driver
  // --------------------------------------------------------------------------
  // A peripheral output takes the pin over the latch; float overrides both.
  assign drive_req = (dir | periph_oe) & ~float_force;
  assign drive_val = periph_oe ? periph_out : latch;
  // An open-drain pin only ever pulls low; a high value leaves it floating.
  assign driving = drive_req & ~(OPEN_DRAIN & drive_val);
  assign pin_out = drive_val;
  assign pin_oe_n = ~driving;

  // --------------------------------------------------------------------------
  // Pull-up
  // --------------------------------------------------------------------------
  // The pull-up is dropped while the pin is driven low to save current.
  assign pullup_en = HAS_PULLUP & pull_bit & ~(driving & ~drive_val);
endmodule

// ==== testbench/gp1_pin_model.sv ====
// Board-side model of the eight port pins and whatever drives them from outside.
`timescale 1ns/1ps
module gp1_pin_model (
  input wire logic mclk,
  input wire logic [gp1_pkg::GP1_W-1:0] pin_out,
  input wire logic [gp1_pkg::GP1_W-1:0] pin_oe_n,
  input wire logic [gp1_pkg::GP1_W-1:0] pin_pullup_en,
  input wire logic [gp1_pkg::GP1_W-1:0] ext_en,
  input wire logic [gp1_pkg::GP1_W-1:0] ext_val,
  output logic [gp1_pkg::GP1_W-1:0] pin_in
);
  import gp1_pkg::*;
  // A pin that nobody drives or pulls wanders, so a stale value never passes.
  logic [GP1_W-1:0] wander_q = 8'h55;
  always @(posedge mclk)
  begin
    wander_q <= ~wander_q;
  end
  always_comb
  begin
    for (int i = 0; i < GP1_W; i++)
    begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = wander_q[i];
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the eight-pin port.
`timescale 1ns/1ps
module tb;
  import gp1_pkg::*;
  localparam logic [GP1_W-1:0] OD = 8'h80;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [GP1_AW-1:0] addr = 4'h0;
  logic [GP1_W-1:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic rd_rmw = 1'b0;
  logic sbw = 1'b0;
  logic fsel = 1'b0;
  logic [1:0] eic = 2'h0;
  logic [1:0] ips = 2'h0;
  logic [GP1_W-1:0] poe = 8'h00;
  logic [GP1_W-1:0] pout = 8'h00;
  logic [GP1_W-1:0] ext_en = 8'h00;
  logic [GP1_W-1:0] ext_val = 8'h00;
  logic [GP1_W-1:0] rdata, pin_in, pin_out, pin_oe_n, pull, pin_to_per;
  logic [GP1_W-1:0] d_m, l_m, pl_m, p_m, v_m, lvl, drv, val, keep;
  logic [GP1_W-1:0] exp_q[$];
  logic rd_seen = 1'b0;
  int compares = 0;
  int miscompares = 0;
  always #50 mclk = ~mclk;
  gp1_port #(.OPEN_DRAIN_MASK(OD)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_rmw(rd_rmw), .rdata(rdata),
    .standby_stop_watch(sbw), .standby_float_select(fsel), .ext_irq_control_zero(eic),
    .irq_pin_select_control(ips), .periph_oe(poe), .periph_out(pout),
    .periph_in(pin_to_per), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pull));
  gp1_pin_model pins (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pull), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // --------------------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------------------
  task automatic cmp(input string what, input logic [GP1_W-1:0] e, input logic [GP1_W-1:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [GP1_AW-1:0] a, input logic [GP1_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [GP1_AW-1:0] a, input logic rmw, input logic [GP1_W-1:0] e);
    @(posedge mclk);
    addr <= a;
    rd_rmw <= rmw;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask
  // Expected pin drive, value and pull-up from the shadow register copies.
  task automatic check_pins();
    drv = (d_m & ~(OD & l_m) & ~p_m) | p_m;
    val = (p_m & v_m) | (~p_m & l_m);
    cmp("pin_oe_n", ~drv, pin_oe_n);
    cmp("pin_out", val & drv, pin_out & drv);
    cmp("pullup", pl_m & ~GP1_NO_PULLUP_MASK & ~(drv & ~val), pull);
  endtask
  // Read results are paired with the oldest queued expectation.
  always @(posedge mclk)
  begin
    if (rd_seen)
      cmp("rdata", exp_q.pop_front(), rdata);
    rd_seen <= rd_stb;
  end
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    void'($urandom(72));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(GP1_OFS_DIR, 1'b0, 8'h00);
    rd(GP1_OFS_LATCH, 1'b1, GP1_RST_LATCH);
    cmp("pin_oe_n", 8'hff, pin_oe_n);
    repeat (8)
    begin
      d_m = 8'($urandom);
      l_m = 8'($urandom);
      pl_m = 8'($urandom);
      p_m = 8'h00;
      ext_val <= 8'($urandom);
      ext_en <= ~d_m;
      wr(GP1_OFS_DIR, d_m);
      wr(GP1_OFS_LATCH, 8'($urandom));
      wr(GP1_OFS_LATCH, l_m);
      wr(GP1_OFS_PULL, pl_m);
      repeat (3) @(posedge mclk);
      #1 check_pins();
      rd(GP1_OFS_LATCH, 1'b0, (l_m & d_m) | (ext_val & ~d_m));
      rd(GP1_OFS_LATCH, 1'b1, l_m);
      rd(GP1_OFS_PULL, 1'b0, pl_m);
      p_m = 8'($urandom) & 8'h7f;
      v_m = 8'($urandom);
      poe <= p_m;
      pout <= v_m;
      ext_en <= ~(d_m | p_m);
      repeat (3) @(posedge mclk);
      #1 check_pins();
      lvl = (p_m & v_m) | (~p_m & d_m & l_m) | (~p_m & ~d_m & ext_val);
      cmp("periph_in", lvl & 8'h7f, pin_to_per & 8'h7f);
      rd(GP1_OFS_LATCH, 1'b0, lvl);
      rd(GP1_OFS_LATCH, 1'b1, l_m);
      p_m = 8'h00;
      poe <= 8'h00;
    end
    // Standby with float clear keeps drivers; with float set all pins let go.
    ext_en <= 8'hff;
    ext_val <= 8'($urandom);
    sbw <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check_pins();
    fsel <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int k = 0; k < 16; k++)
    begin
      eic <= 2'(k);
      ips <= 2'(k >> 2);
      @(posedge mclk);
      #1 keep = {1'b0, eic[1] & ips[1], 1'b0, eic[0] & ips[0], 4'h0};
      cmp("pin_oe_n", 8'hff, pin_oe_n);
      cmp("periph_in", ext_val & keep, pin_to_per);
    end
    sbw <= 1'b0;
    fsel <= 1'b0;
    wr(4'hf, 8'h5a);
    rd(4'hf, 1'b0, 8'h00);
    rd(GP1_OFS_LATCH, 1'b1, l_m);
    #1 check_pins();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(GP1_OFS_DIR, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    give_verdict();
  end
  // The whole run needs well under two thousand cycles.
  initial
  begin
    #2000000;
    miscompares++;
    give_verdict();
  end
endmodule
